// ---- bench/gpt_pad_model.sv ----
// pad and external circuit attached to the gpio pin
`default_nettype none
module gpt_pad_model (
  input wire logic mclk,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  input wire logic extEn,
  input wire logic extLvl,
  output logic pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  // a floating pad toggles so no fixed level is read by luck
  always @(posedge mclk) flip <= !flip;
  always_comb begin
    if (pinOe) pinIn = pinOut;
    else if (extEn) pinIn = extLvl;
    else if (pullUpEn) pinIn = 1'b1;
    else if (pullDownEn) pinIn = 1'b0;
    else pinIn = flip;
  end
endmodule
`default_nettype wire

// ---- bench/gpt_pin_assertions.sv ----
// bus and pad output properties of the gpio pin block
`default_nettype none
module gpt_pin_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  input wire logic [1:0] driveLevel,
  input wire logic altEn,
  input wire logic [3:0] altSelect,
  input wire logic altIn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_PULL_ONE: assert property (!(pullUpEn && pullDownEn))
    else $error("both pulls on");
  AST_DRV_CODE: assert property (driveLevel != 2'h3)
    else $error("bad drive code");
  AST_ALT_SEL: assert property (!altEn |-> altSelect == 4'h0)
    else $error("selector outside alt");
  AST_ALT_IN: assert property (!altEn |-> !altIn)
    else $error("peripheral still fed");
  AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  C_WR: cover property (s_axi_bvalid && s_axi_bready);
  C_RD: cover property (s_axi_rvalid && s_axi_rready);
  C_ALT: cover property (altEn && altSelect != 4'h0);
endmodule
`default_nettype wire

// ---- bench/gpt_pin_tb_top.sv ----
// self-checking bench for the gpio pin with pulse timer
`default_nettype none
module gpt_pin_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, altOut = 1'b0, altOe = 1'b0, extEn = 1'b0, extLvl = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pinIn, pinOut, pinOe, pullUpEn, pullDownEn, altEn, altIn;
  logic [1:0] s_axi_bresp, s_axi_rresp, driveLevel, rr;
  logic [3:0] altSelect;
  logic [31:0] s_axi_rdata, rv;
  int miscompares = 0;
  int nTests = 0;
  `define CHK(a, e) begin nTests++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
  always #25 mclk = ~mclk;
  gpt_pin gpt_pin_inst (.*);
  gpt_pad_model gpt_pad_model_inst (.*);
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // inputs only move on rising edges, so the mid-cycle look equals the next edge's sample
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic ta, tv;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tv);
    s_axi_rready <= 1'b0;
  endtask
  // pads follow config two cycles after the write is taken
  task automatic wc(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    wt(3);
    @(negedge mclk);
  endtask
  task automatic lvl;
    for (int l = 0; l < 2; l++) begin
      @(posedge mclk);
      extEn <= 1'b1;
      extLvl <= 1'(l);
      wt(4);
      rd(gpt_pkg::OFS_VALUE);
      `CHK(rv[0], 1'(l))
    end
  endtask
  task automatic tm(input logic p, input int pre, input int len, input logic [31:0] lo,
                    input logic [31:0] hi);
    @(posedge mclk);
    extEn <= 1'b1;
    extLvl <= (pre == 0) ? p : !p;
    wr(gpt_pkg::OFS_TIMER, 32'h0000_0002 | 32'(p));
    if (pre > 0) begin
      wt(pre);
      extLvl <= p;
    end
    wt(len);
    extLvl <= !p;
    wt(300);
    rd(gpt_pkg::OFS_TIMER);
    `CHK(rv >= lo && rv <= hi, 1'b1)
  endtask
  task automatic t_reset;
    @(negedge mclk);
    `CHK(pinOe, 1'b0)
    `CHK({pullUpEn, pullDownEn, driveLevel, altEn}, 5'h00)
    rd(gpt_pkg::OFS_LIMIT);
    `CHK(rv, gpt_pkg::LIMIT_RESET)
    rd(4'h2);
    `CHK(rr, gpt_pkg::RESP_SLVERR)
    $display("reset test done");
  endtask
  task automatic t_cfg;
    wc(gpt_pkg::OFS_VALUE, 32'h0000_0100);
    `CHK(pinOe, 1'b0)
    wc(gpt_pkg::OFS_CONFIG, 32'h0800_0001);
    `CHK({pinOe, pinOut}, 2'b11)
    wc(gpt_pkg::OFS_VALUE, 32'h0000_0000);
    `CHK(pinOut, 1'b0)
    wc(gpt_pkg::OFS_CONFIG, 32'h1000_0010);
    `CHK({pinOe, pullUpEn, pullDownEn}, 3'b110)
    for (int i = 0; i < 4; i++) begin
      wc(gpt_pkg::OFS_CONFIG, 32'h2000_0000 | (32'(i) << 8));
      `CHK(driveLevel, (i == 3) ? 2'h2 : 2'(i))
    end
    wc(gpt_pkg::OFS_CONFIG, 32'h5000_5020);
    `CHK({pullUpEn, pullDownEn, altEn, altSelect}, 7'h20)
    $display("config test done");
  endtask
  task automatic t_sink;
    wc(gpt_pkg::OFS_CONFIG, 32'h0800_0002);
    `CHK({pinOe, pinOut}, 2'b10)
    wc(gpt_pkg::OFS_VALUE, 32'h0000_0001);
    `CHK(pinOe, 1'b0)
    lvl();
    wc(gpt_pkg::OFS_CONFIG, 32'h0800_0000);
    lvl();
    $display("sink test done");
  endtask
  task automatic t_alt;
    @(posedge mclk);
    extEn <= 1'b0;
    altOe <= 1'b1;
    altOut <= 1'b1;
    wc(gpt_pkg::OFS_CONFIG, 32'h4800_5003);
    `CHK({altEn, altSelect, pinOe, pinOut}, 7'h57)
    `CHK(altIn, 1'b1)
    wc(gpt_pkg::OFS_CONFIG, 32'h0800_0004);
    `CHK({altEn, pinOe}, 2'b10)
    @(posedge mclk);
    altOut <= 1'b0;
    wt(4);
    @(negedge mclk);
    `CHK({pinOe, pinOut}, 2'b10)
    wc(gpt_pkg::OFS_CONFIG, 32'h0800_0000);
    `CHK({altEn, altSelect, pinOe}, 6'h00)
    $display("alt test done");
  endtask
  task automatic t_timer;
    wc(gpt_pkg::OFS_LIMIT, 32'h0000_0005);
    tm(1'b1, 40, 60, 32'h0000_0002, 32'h0000_0004);
    tm(1'b0, 40, 60, 32'h0000_0002, 32'h0000_0004);
    tm(1'b1, 0, 60, 32'h0000_0002, 32'h0000_0004);
    tm(1'b1, 300, 1, gpt_pkg::RESULT_WAIT_TO, gpt_pkg::RESULT_WAIT_TO);
    tm(1'b0, 0, 300, gpt_pkg::RESULT_MEAS_TO, gpt_pkg::RESULT_MEAS_TO);
    $display("timer test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    wt(2);
    rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_sink();
    t_alt();
    t_timer();
    final_report();
  end
  initial begin
    wt(20000);
    miscompares++;
    final_report();
  end
endmodule
bind gpt_pin gpt_pin_assertions gpt_pin_assertions_inst (.mclk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pullUpEn,
  .pullDownEn, .driveLevel, .altEn, .altSelect, .altIn);
`default_nettype wire

// ---- inc/gpt_pkg.sv ----
// constants, types and register map of the gpio pin with pulse timer
// Overview of operation
// - input mode keeps the pin driver released (high impedance).
// - sink-only mode drives low for buffer 0, releases for buffer 1.
// - peripheral-owned mode lets the alternate peripheral drive the pin.
// - peripheral sink-only mode is peripheral-owned with a low-or-release output.
// - switching to input, push-pull or sink-only detaches the peripheral.
// - pull selection offers none, weak pull-up or weak pull-down.
// - drive strength offers weakest, middle and strongest levels.
// - alternate selector acts only in the two peripheral-owned modes.
// - a configuration write changes only the fields it supplies.
// - level read returns 0 for low voltage, 1 for high.
// - input mode reads the live sampled pin; push-pull read is undefined.
// - sink-only read is live while buffer holds 1, undefined otherwise.
// - value write stores 1 for any nonzero value, else 0.
// - input-mode write only updates the buffer; it drives once output selected.
// - push-pull write updates buffer and driven level immediately.
// - timer measures a low pulse for polarity 0, high for 1.
// - timer waits for the polarity first, then times while it matches.
// - duration in microseconds; limit programmable, default 1000000.
// - wait timeout returns -2, measure timeout returns -1, same limit.
`default_nettype none
package gpt_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
  localparam logic [31:0] LIMIT_RESET = 32'h000F_4240;
  localparam logic [31:0] RESULT_WAIT_TO = 32'hFFFF_FFFE;
  localparam logic [31:0] RESULT_MEAS_TO = 32'hFFFF_FFFF;

  // register byte offsets
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_VALUE = 4'h4;
  localparam logic [3:0] OFS_LIMIT = 4'h8;
  localparam logic [3:0] OFS_TIMER = 4'hC;

  // config word: bit 27..31 = supply flags for mode, pull, drive, alt, value
  localparam int MODE_LSB = 0;
  localparam int PULL_LSB = 4;
  localparam int DRIVE_LSB = 8;
  localparam int ALT_LSB = 12;
  localparam int VAL_BIT = 16;
  localparam int SUP_MODE = 27;
  localparam int SUP_PULL = 28;
  localparam int SUP_DRIVE = 29;
  localparam int SUP_ALT = 30;
  localparam int SUP_VAL = 31;
  // timer word: write bit 0 polarity, bit 1 start; read bit 0 busy, bit 2 polarity until done, then the result
  localparam int TMR_POL = 0;
  localparam int TMR_START = 1;
  localparam int TMR_BUSY = 0;
  localparam int TMR_DONE = 1;
  localparam int TMR_LEVEL = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    GPT_IN = 3'h0,
    GPT_OUT = 3'h1,
    GPT_SINK = 3'h2,
    GPT_ALT = 3'h3,
    GPT_ALT_SINK = 3'h4
  } gpt_mode_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_UP = 2'h1,
    PULL_DOWN = 2'h2
  } gpt_pull_t;

  typedef enum logic [1:0] {
    DRV_WEAK = 2'h0,
    DRV_MIDDLE_DRIVE = 2'h1,
    DRV_STRONG = 2'h2
  } gpt_drive_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'h0,
    TS_WAIT = 2'h1,
    TS_MEAS = 2'h2
  } gpt_tstate_t;
endpackage
`default_nettype wire

// ---- src/gpt_pin.sv ----
// gpio pin controller with pulse-width measure timer, axi4-lite slave
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none
module gpt_pin (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pullUpEn,
  output logic pullDownEn,
  output logic [1:0] driveLevel,
  output logic altEn,
  output logic [3:0] altSelect,
  input wire logic altOut,
  input wire logic altOe,
  output logic altIn
);
  typedef struct packed {
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    gpt_pkg::gpt_mode_t mode;
    gpt_pkg::gpt_pull_t pull;
    gpt_pkg::gpt_drive_t drive;
    logic [3:0] alt;
    logic outBuf;
    logic [31:0] limit;
    logic polarity;
    gpt_pkg::gpt_tstate_t tState;
    logic done;
    logic [31:0] result;
    logic [31:0] micros;
    logic [4:0] tickCnt;
    logic sync1;
    logic sync2;
    logic pinOut;
    logic pinOe;
    logic pullUpEn;
    logic pullDownEn;
    logic [1:0] driveLevel;
    logic altEn;
    logic [3:0] altSelect;
    logic altIn;
  } gpt_state_t;

  gpt_state_t st;
  gpt_state_t next_st;

  always_comb begin
    logic tick;
    logic doWrite;
    logic [31:0] wd;
    logic pinLvl;
    logic drvOut;
    logic drvOe;
    tick = 1'b0;
    doWrite = 1'b0;
    wd = 32'h0000_0000;
    pinLvl = 1'b0;
    drvOut = 1'b0;
    drvOe = 1'b0;
    next_st = st;

    // two stages before anything looks at the pin
    next_st.sync1 = pinIn;
    next_st.sync2 = st.sync1;
    pinLvl = st.sync2;

    // microsecond tick divider
    if (st.tickCnt == gpt_pkg::TICK_LAST) begin
      next_st.tickCnt = 5'h00;
      tick = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 5'h01;
    end

    // write channels taken independently, either order
    if (s_axi_awvalid && !st.awHeld) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.bValid) begin
      doWrite = 1'b1;
      wd = st.wData;
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = gpt_pkg::RESP_OKAY;
    end

    // pulse timer sequencing
    unique case (st.tState)
      gpt_pkg::TS_IDLE: begin
      end
      gpt_pkg::TS_WAIT: begin
        if (pinLvl == st.polarity) begin
          next_st.tState = gpt_pkg::TS_MEAS;
          next_st.micros = 32'h0000_0000;
        end else if (tick) begin
          if (st.micros + 32'h0000_0001 >= st.limit) begin
            next_st.tState = gpt_pkg::TS_IDLE;
            next_st.done = 1'b1;
            next_st.result = gpt_pkg::RESULT_WAIT_TO;
          end else begin
            next_st.micros = st.micros + 32'h0000_0001;
          end
        end
      end
      gpt_pkg::TS_MEAS: begin
        if (pinLvl != st.polarity) begin
          next_st.tState = gpt_pkg::TS_IDLE;
          next_st.done = 1'b1;
          next_st.result = st.micros;
        end else if (tick) begin
          if (st.micros + 32'h0000_0001 >= st.limit) begin
            next_st.tState = gpt_pkg::TS_IDLE;
            next_st.done = 1'b1;
            next_st.result = gpt_pkg::RESULT_MEAS_TO;
          end else begin
            next_st.micros = st.micros + 32'h0000_0001;
          end
        end
      end
      default: begin
        next_st.tState = gpt_pkg::TS_IDLE;
      end
    endcase

    // register writes
    if (doWrite) begin
      unique case (st.awAddr)
        gpt_pkg::OFS_CONFIG: begin
          // only supplied fields change
          if (wd[gpt_pkg::SUP_MODE] && wd[gpt_pkg::MODE_LSB +: 3] <= 3'h4) begin
            next_st.mode = gpt_pkg::gpt_mode_t'(wd[gpt_pkg::MODE_LSB +: 3]);
          end
          if (wd[gpt_pkg::SUP_PULL] && wd[gpt_pkg::PULL_LSB +: 2] != 2'h3) begin
            next_st.pull = gpt_pkg::gpt_pull_t'(wd[gpt_pkg::PULL_LSB +: 2]);
          end
          if (wd[gpt_pkg::SUP_DRIVE] && wd[gpt_pkg::DRIVE_LSB +: 2] != 2'h3) begin
            next_st.drive = gpt_pkg::gpt_drive_t'(wd[gpt_pkg::DRIVE_LSB +: 2]);
          end
          if (wd[gpt_pkg::SUP_ALT]) begin
            next_st.alt = wd[gpt_pkg::ALT_LSB +: 4];
          end
          if (wd[gpt_pkg::SUP_VAL]) begin
            next_st.outBuf = wd[gpt_pkg::VAL_BIT];
          end
        end
        gpt_pkg::OFS_VALUE: begin
          next_st.outBuf = |wd;
        end
        gpt_pkg::OFS_LIMIT: begin
          next_st.limit = wd;
        end
        gpt_pkg::OFS_TIMER: begin
          if (wd[gpt_pkg::TMR_START]) begin
            next_st.polarity = wd[gpt_pkg::TMR_POL];
            next_st.tState = gpt_pkg::TS_WAIT;
            next_st.micros = 32'h0000_0000;
            next_st.done = 1'b0;
            next_st.result = 32'h0000_0000;
          end
        end
        default: begin
          next_st.bResp = gpt_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    if (s_axi_arvalid && !st.rValid) begin
      next_st.rValid = 1'b1;
      next_st.rResp = gpt_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        gpt_pkg::OFS_CONFIG: begin
          next_st.rData = 32'h0000_0000;
          next_st.rData[gpt_pkg::MODE_LSB +: 3] = st.mode;
          next_st.rData[gpt_pkg::PULL_LSB +: 2] = st.pull;
          next_st.rData[gpt_pkg::DRIVE_LSB +: 2] = st.drive;
          next_st.rData[gpt_pkg::ALT_LSB +: 4] = st.alt;
          next_st.rData[gpt_pkg::VAL_BIT] = st.outBuf;
        end
        gpt_pkg::OFS_VALUE: begin
          // live sampled level; meaningless in push-pull or sink driving low
          next_st.rData = {31'h0000_0000, pinLvl};
        end
        gpt_pkg::OFS_LIMIT: begin
          next_st.rData = st.limit;
        end
        gpt_pkg::OFS_TIMER: begin
          next_st.rData = 32'h0000_0000;
          next_st.rData[gpt_pkg::TMR_BUSY] = (st.tState != gpt_pkg::TS_IDLE);
          next_st.rData[gpt_pkg::TMR_DONE] = st.done;
          next_st.rData[gpt_pkg::TMR_LEVEL] = st.polarity;
        end
        default: begin
          next_st.rData = 32'h0000_0000;
          next_st.rResp = gpt_pkg::RESP_SLVERR;
        end
      endcase
      if (s_axi_araddr == gpt_pkg::OFS_TIMER + 4'h0 && st.done) begin
        next_st.rData = st.result;
      end
    end

    // pad driver from the currently registered configuration
    unique case (st.mode)
      gpt_pkg::GPT_IN: begin
        drvOut = st.outBuf;
        drvOe = 1'b0;
      end
      gpt_pkg::GPT_OUT: begin
        drvOut = st.outBuf;
        drvOe = 1'b1;
      end
      gpt_pkg::GPT_SINK: begin
        drvOut = 1'b0;
        drvOe = !st.outBuf;
      end
      gpt_pkg::GPT_ALT: begin
        drvOut = altOut;
        drvOe = altOe;
      end
      gpt_pkg::GPT_ALT_SINK: begin
        drvOut = 1'b0;
        drvOe = altOe && !altOut;
      end
      default: begin
        drvOut = 1'b0;
        drvOe = 1'b0;
      end
    endcase
    next_st.pinOut = drvOut;
    next_st.pinOe = drvOe;
    next_st.pullUpEn = (st.pull == gpt_pkg::PULL_UP);
    next_st.pullDownEn = (st.pull == gpt_pkg::PULL_DOWN);
    next_st.driveLevel = st.drive;
    // any non-peripheral mode detaches the alternate function
    next_st.altEn = (st.mode == gpt_pkg::GPT_ALT) || (st.mode == gpt_pkg::GPT_ALT_SINK);
    next_st.altSelect = next_st.altEn ? st.alt : 4'h0;
    next_st.altIn = next_st.altEn ? pinLvl : 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= gpt_pkg::GPT_IN;
      st.pull <= gpt_pkg::PULL_NONE;
      st.drive <= gpt_pkg::DRV_WEAK;
      st.limit <= gpt_pkg::LIMIT_RESET;
      st.tState <= gpt_pkg::TS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ready flags low while a channel holds an untaken item
  always_comb begin
    s_axi_awready = !st.awHeld;
    s_axi_wready = !st.wHeld;
    s_axi_arready = !st.rValid;
  end
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp = st.bResp;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign pinOut = st.pinOut;
  assign pinOe = st.pinOe;
  assign pullUpEn = st.pullUpEn;
  assign pullDownEn = st.pullDownEn;
  assign driveLevel = st.driveLevel;
  assign altEn = st.altEn;
  assign altSelect = st.altSelect;
  assign altIn = st.altIn;
endmodule
`default_nettype wire
